/* File: include/dlsc_pkg.sv */
// Constants, commands and types for the dual low-side switch controller
package dlsc_pkg;
    localparam int CLK_NS = 8;
    localparam int FILTER_US = 200;
    localparam int OFFDLY_FAST_US = 50;
    localparam int OFFDLY_SLOW_US = 150;
    localparam int WAKE_US = 50;
    localparam int FILTER_CYC = FILTER_US * 1000 / CLK_NS;
    localparam int OFFDLY_FAST_CYC = OFFDLY_FAST_US * 1000 / CLK_NS;
    localparam int OFFDLY_SLOW_CYC = OFFDLY_SLOW_US * 1000 / CLK_NS;
    localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
    localparam int CNT_W = 16;
    localparam int FRAME_BITS = 8;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_DIAG = 3'h1;
    localparam logic [2:0] CMD_OUTCFG = 3'h2;
    localparam logic [2:0] CMD_IOCFG = 3'h3;
    localparam logic [2:0] CMD_RESET = 3'h4;
    localparam logic [2:0] CMD_SLEEP = 3'h5;
    localparam logic [2:0] CMD_WAKE = 3'h6;
    localparam logic [2:0] CMD_ONOFF = 3'h7;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 5;
    localparam int BIT_OVL2 = 4;
    localparam int BIT_OVL1 = 3;
    localparam int BIT_LATCH = 2;
    localparam int BIT_SLEW2 = 1;
    localparam int BIT_SLEW1 = 0;
    localparam int BIT_STATSPI = 4;
    localparam int BIT_SRC_HI = 3;
    localparam int BIT_SRC_LO = 2;
    localparam int BIT_SENSE_HI = 1;
    localparam int BIT_SENSE_LO = 0;
    localparam int BIT_ON2 = 4;
    localparam int BIT_ON1 = 3;
    localparam logic [1:0] SRC_PAR = 2'h0;
    localparam logic [1:0] SRC_SER = 2'h1;
    localparam logic [1:0] SRC_OR = 2'h2;
    localparam logic [1:0] SRC_AND = 2'h3;
    typedef enum logic [1:0] {
        DLSC_RUN = 2'h0,
        DLSC_SLEEP = 2'h1,
        DLSC_WAKING = 2'h3
    } dlsc_mode_type;
endpackage : dlsc_pkg

/* File: hw/dlsc_serial_port.sv */
// Serial frame shifter sampled on the system clock
`timescale 1ns/10ps
module dlsc_serial_port
    import dlsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclkPin,
    input wire logic csPin_n,
    input wire logic siPin,
    input wire logic [7:0] diagWord,
    output logic soData,
    output logic soDrive_n,
    output logic frameValid,
    output logic [7:0] frameData,
    output logic frameStart
);
    typedef struct packed {
        logic [1:0] sclkSync;
        logic [1:0] csSync;
        logic [1:0] siSync;
        logic sclkOld;
        logic csOld;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [3:0] count;
        logic soBit;
        logic valid;
        logic [7:0] data;
    } dlsc_sp_type;
    dlsc_sp_type s_q, s_d;
    logic sclkS, csS, siS;

    assign sclkS = s_q.sclkSync[1];
    assign csS = s_q.csSync[1];
    assign siS = s_q.siSync[1];

    // Synchronise pins, shift on the sampled clock edges
    always_comb begin
        s_d = s_q;
        s_d.sclkSync = {s_q.sclkSync[0], sclkPin};
        s_d.csSync = {s_q.csSync[0], csPin_n};
        s_d.siSync = {s_q.siSync[0], siPin};
        s_d.sclkOld = sclkS;
        s_d.csOld = csS;
        s_d.valid = 1'b0;
        if (s_q.csOld && !csS) begin
            s_d.shiftOut = diagWord;
            s_d.soBit = diagWord[FRAME_BITS-1];
            s_d.count = 4'h0;
        end else if (!csS) begin
            if (s_q.sclkOld && !sclkS) begin
                s_d.shiftIn = {s_q.shiftIn[6:0], siS};
                if (s_q.count != 4'(FRAME_BITS))
                    s_d.count = s_q.count + 4'h1;
            end
            if (!s_q.sclkOld && sclkS && s_q.count != 4'h0) begin
                s_d.shiftOut = {s_q.shiftOut[6:0], 1'b0};
                s_d.soBit = s_q.shiftOut[6];
            end
        end
        if (!s_q.csOld && csS) begin
            s_d.valid = (s_q.count == 4'(FRAME_BITS));
            s_d.data = s_q.shiftIn;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{sclkSync: 2'h0, csSync: 2'h3, siSync: 2'h0,
                     sclkOld: 1'b0, csOld: 1'b1, shiftIn: 8'h00,
                     shiftOut: 8'h00, count: 4'h0, soBit: 1'b0,
                     valid: 1'b0, data: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign soData = s_q.soBit;
    assign soDrive_n = csS;
    assign frameValid = s_q.valid;
    assign frameData = s_q.data;
    assign frameStart = s_q.csOld && !csS;

    a_frame_length: assert property (@(posedge clk) disable iff (rst)
        frameValid |-> $past(s_q.count) == 4'(FRAME_BITS))
        else $error("frame accepted without eight bits");
endmodule : dlsc_serial_port

/* File: hw/dlsc_channel.sv */
// One output channel: source select, overtemperature and overload logic
`timescale 1ns/10ps
module dlsc_channel
    import dlsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic parIn,
    input wire logic serBit,
    input wire logic [1:0] srcSel,
    input wire logic ovlMode,
    input wire logic latchMode,
    input wire logic slowSlew,
    input wire logic chanOverTemp,
    input wire logic limitActive,
    input wire logic forceOff,
    input wire logic clearLatches,
    output logic driveOn,
    output logic otFault,
    output logic ovlFault,
    output logic request
);
    typedef struct packed {
        logic reqOld;
        logic otLatch;
        logic ovlLatch;
        logic ovlReport;
        logic [CNT_W-1:0] limCount;
    } dlsc_ch_type;
    dlsc_ch_type c_q, c_d;
    logic [CNT_W-1:0] offLimit;
    logic rise;
    logic onReq;

    // Requested state from the selected source, both active high
    always_comb begin
        case (srcSel)
            SRC_PAR: request = parIn;
            SRC_SER: request = serBit;
            SRC_OR: request = parIn | serBit;
            SRC_AND: request = parIn & serBit;
            default: request = 1'b0;
        endcase
    end

    assign offLimit = slowSlew ? CNT_W'(OFFDLY_SLOW_CYC)
                               : CNT_W'(OFFDLY_FAST_CYC);
    assign rise = request && !c_q.reqOld;
    // Channel commanded on; its temperature sensor is live only then
    assign onReq = request && !forceOff && !c_q.ovlLatch &&
                   !(c_q.otLatch && latchMode);
    assign driveOn = onReq && !chanOverTemp;

    // Latches and the limiting timer
    always_comb begin
        c_d = c_q;
        c_d.reqOld = request;
        // Clears go first so a fault in the same cycle still latches
        if (clearLatches) begin
            c_d.ovlReport = 1'b0;
            c_d.otLatch = c_q.otLatch & latchMode;
        end
        if (forceOff && clearLatches)
            c_d.ovlLatch = 1'b0;
        if (rise) begin
            c_d.otLatch = 1'b0;
            c_d.ovlLatch = 1'b0;
        end
        if (driveOn && limitActive) begin
            if (c_q.limCount != '1)
                c_d.limCount = c_q.limCount + CNT_W'(1);
        end else begin
            c_d.limCount = '0;
        end
        if (ovlMode) begin
            if (c_q.limCount >= CNT_W'(FILTER_CYC))
                c_d.ovlReport = 1'b1;
        end else if (c_q.limCount >= offLimit) begin
            c_d.ovlLatch = 1'b1;
            c_d.ovlReport = 1'b1;
            c_d.limCount = '0;
        end
        if (chanOverTemp && onReq)
            c_d.otLatch = 1'b1;
        else if (!latchMode && !chanOverTemp && !rise)
            c_d.otLatch = c_d.otLatch & ~request;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            c_q <= '{reqOld: 1'b0, otLatch: 1'b0, ovlLatch: 1'b0,
                     ovlReport: 1'b0, limCount: '0};
        end else begin
            c_q <= c_d;
        end
    end

    assign otFault = c_q.otLatch;
    assign ovlFault = c_q.ovlReport;

    a_ot_off: assert property (@(posedge clk) disable iff (rst)
        chanOverTemp |-> !driveOn)
        else $error("channel driven during overtemperature");
    a_ot_record: assert property (@(posedge clk) disable iff (rst)
        (chanOverTemp && onReq) |=> c_q.otLatch)
        else $error("overtemperature not recorded");
    a_offdelay_fast: assert property (@(posedge clk) disable iff (rst)
        (!ovlMode && !slowSlew && c_q.limCount >= offLimit)
        |=> c_q.ovlLatch && !driveOn)
        else $error("overload switch-off missing");
    a_latch_hold: assert property (@(posedge clk) disable iff (rst)
        (c_q.ovlLatch && !rise && !(forceOff && clearLatches))
        |=> c_q.ovlLatch)
        else $error("overload latch cleared without rising request");
endmodule : dlsc_channel

/* File: hw/dlsc_top.sv */
// Dual low-side switch control and protection logic
`timescale 1ns/10ps
module dlsc_top
    import dlsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclkPin,
    input wire logic csPin_n,
    input wire logic siPin,
    input wire logic parallel_drive_ch1,
    input wire logic parallel_drive_ch2,
    input wire logic [1:0] chanOverTemp,
    input wire logic [1:0] limitActive,
    input wire logic chipOverTemp,
    output logic soData,
    output logic soEnable_n,
    output logic channel1_status_pin,
    output logic channel2_status_pin,
    output logic [1:0] gateOn,
    output logic [1:0] slowSlew,
    output logic [1:0] senseSel,
    output logic sleeping,
    output logic tempWarn
);
    typedef struct packed {
        logic [3:0] parSync;
        logic [3:0] otSync;
        logic [3:0] limSync;
        logic [1:0] warnSync;
        dlsc_mode_type mode;
        logic [CNT_W-1:0] wakeCount;
        logic [1:0] ovlMode;
        logic latchMode;
        logic [1:0] slew;
        logic statusSpi;
        logic [1:0] srcSel;
        logic [1:0] sense;
        logic [1:0] onOff;
        logic badFrame;
        logic [1:0] gate;
        logic [1:0] stat;
        logic warn;
    } dlsc_top_type;
    dlsc_top_type t_q, t_d;
    logic frameValid, frameStart;
    logic [7:0] frameData, diagWord;
    logic [2:0] cmd;
    logic [1:0] parS, otS, limS, drive, otF, ovlF, req;
    logic forceOff, clearDiag, spiDrive_n;

    assign parS = t_q.parSync[3:2];
    assign otS = t_q.otSync[3:2];
    assign limS = t_q.limSync[3:2];
    assign cmd = frameData[CMD_MSB:CMD_LSB];
    assign forceOff = (t_q.mode != DLSC_RUN);
    // Diagnosis cleared after a valid frame other than CMD_NONE, and while asleep or waking
    assign clearDiag = (frameValid && cmd != CMD_NONE) || forceOff;

    // Diagnosis word: warning, frame error, per channel overload and temp
    assign diagWord = forceOff ? 8'h00 :
        {t_q.warn, t_q.badFrame, 2'h0, ovlF[1], otF[1], ovlF[0], otF[0]};

    dlsc_serial_port u_port (
        .clk(clk),
        .rst(rst),
        .sclkPin(sclkPin),
        .csPin_n(csPin_n),
        .siPin(siPin),
        .diagWord(diagWord),
        .soData(soData),
        .soDrive_n(spiDrive_n),
        .frameValid(frameValid),
        .frameData(frameData),
        .frameStart(frameStart)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gCh
            dlsc_channel u_ch (
                .clk(clk),
                .rst(rst),
                .parIn(parS[g]),
                .serBit(t_q.onOff[g]),
                .srcSel(t_q.srcSel),
                .ovlMode(t_q.ovlMode[g]),
                .latchMode(t_q.latchMode),
                .slowSlew(t_q.slew[g]),
                .chanOverTemp(otS[g]),
                .limitActive(limS[g]),
                .forceOff(forceOff),
                .clearLatches(clearDiag),
                .driveOn(drive[g]),
                .otFault(otF[g]),
                .ovlFault(ovlF[g]),
                .request(req[g])
            );
        end
    endgenerate

    // Synchronisers, command decode, mode sequencing
    always_comb begin
        t_d = t_q;
        t_d.parSync = {t_q.parSync[1:0],
                       parallel_drive_ch2, parallel_drive_ch1};
        t_d.otSync = {t_q.otSync[1:0], chanOverTemp};
        t_d.limSync = {t_q.limSync[1:0], limitActive};
        t_d.warnSync = {t_q.warnSync[0], chipOverTemp};
        t_d.warn = t_q.warnSync[1];
        t_d.gate = drive;
        // Status pin mirrors request, inverted on a fault of its own channel
        t_d.stat = req ^ {ovlF[1] | otF[1], ovlF[0] | otF[0]};
        if (t_q.mode == DLSC_WAKING) begin
            if (t_q.wakeCount >= CNT_W'(WAKE_CYC))
                t_d.mode = DLSC_RUN;
            else
                t_d.wakeCount = t_q.wakeCount + CNT_W'(1);
        end
        if (frameStart && t_q.mode == DLSC_RUN)
            t_d.badFrame = 1'b0;
        if (frameValid) begin
            if (t_q.mode == DLSC_SLEEP) begin
                if (cmd == CMD_WAKE) begin
                    t_d.mode = DLSC_WAKING;
                    t_d.wakeCount = '0;
                end
            end else begin
                case (cmd)
                    CMD_OUTCFG: begin
                        t_d.ovlMode = {frameData[BIT_OVL2],
                                       frameData[BIT_OVL1]};
                        t_d.latchMode = frameData[BIT_LATCH];
                        t_d.slew = {frameData[BIT_SLEW2],
                                    frameData[BIT_SLEW1]};
                    end
                    CMD_IOCFG: begin
                        t_d.statusSpi = frameData[BIT_STATSPI];
                        t_d.srcSel = frameData[BIT_SRC_HI:BIT_SRC_LO];
                        t_d.sense = frameData[BIT_SENSE_HI:BIT_SENSE_LO];
                    end
                    CMD_RESET: begin
                        t_d.onOff = 2'h0;
                        t_d.badFrame = 1'b0;
                    end
                    CMD_SLEEP: begin
                        t_d.mode = DLSC_SLEEP;
                        t_d.onOff = 2'h0;
                    end
                    CMD_ONOFF: begin
                        t_d.onOff = {frameData[BIT_ON2],
                                     frameData[BIT_ON1]};
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (t_q.mode != DLSC_RUN)
            t_d.onOff = 2'h0;
    end

    // Register state; power-up leaves outputs off, settings at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            t_q <= '{parSync: 4'h0, otSync: 4'h0, limSync: 4'h0,
                     warnSync: 2'h0, mode: DLSC_RUN, wakeCount: '0,
                     ovlMode: 2'h0, latchMode: 1'b0, slew: 2'h0,
                     statusSpi: 1'b0, srcSel: SRC_PAR, sense: 2'h0,
                     onOff: 2'h0, badFrame: 1'b0, gate: 2'h0,
                     stat: 2'h0, warn: 1'b0};
        end else begin
            t_q <= t_d;
        end
    end

    assign gateOn = t_q.gate;
    assign slowSlew = t_q.slew;
    assign senseSel = t_q.sense;
    assign sleeping = (t_q.mode != DLSC_RUN);
    assign tempWarn = t_q.warn;
    assign soEnable_n = t_q.statusSpi ? spiDrive_n : 1'b1;
    // Pin 1 is fault flag in serial mode, status pin otherwise
    assign channel1_status_pin = t_q.statusSpi ?
        !(|{ovlF, otF}) : t_q.stat[0];
    assign channel2_status_pin = t_q.stat[1];

    a_sleep_off: assert property (@(posedge clk) disable iff (rst)
        sleeping |=> gateOn == 2'h0)
        else $error("output on during sleep");
    a_sleep_clear: assert property (@(posedge clk) disable iff (rst)
        (frameValid && cmd == CMD_SLEEP && !sleeping)
        |=> t_q.onOff == 2'h0 && sleeping)
        else $error("sleep did not clear on/off");
    a_cfg_keep: assert property (@(posedge clk) disable iff (rst)
        (sleeping && !frameValid) |=> $stable(t_q.ovlMode)
        && $stable(t_q.slew) && $stable(t_q.srcSel))
        else $error("configuration lost in sleep");
    a_wake_only: assert property (@(posedge clk) disable iff (rst)
        (t_q.mode == DLSC_SLEEP && !(frameValid && cmd == CMD_WAKE))
        |=> t_q.mode == DLSC_SLEEP)
        else $error("left sleep without wake");
    a_ser_off: assert property (@(posedge clk) disable iff (rst)
        (t_q.mode == DLSC_WAKING) |=> t_q.onOff == 2'h0)
        else $error("serial bits set after wake");
    a_warn_follow: assert property (@(posedge clk) disable iff (rst)
        $rose(t_q.warnSync[1]) |=> tempWarn)
        else $error("warning flag not raised");
    a_onoff_write: assert property (@(posedge clk) disable iff (rst)
        (frameValid && cmd == CMD_ONOFF && !sleeping)
        |=> t_q.onOff == $past({frameData[BIT_ON2], frameData[BIT_ON1]}))
        else $error("on/off latch not written");
endmodule : dlsc_top

/* File: dv/dlsc_host_model.sv */
// Host model driving the serial port of the switch controller
`timescale 1ns/10ps
module dlsc_host_model (
    output logic sclkPin,
    output logic csPin_n,
    output logic siPin,
    input wire logic soData,
    input wire logic soEnable_n
);
    // Idle levels match the pin pulls: clock and data low, select high
    initial begin
        sclkPin = 1'b0;
        csPin_n = 1'b1;
        siPin = 1'b0;
    end

    // One access of nBits bits; rx collects the returned diagnosis bits
    task automatic send(input logic [7:0] f, input int nBits,
                        output logic [7:0] rx);
        rx = 8'h00;
        #3 csPin_n = 1'b0; // Clock is low at the select edge
        #200;
        for (int i = 0; i < nBits; i++) begin
            #20 siPin = f[7 - i]; // MSB first
            #20 sclkPin = 1'b1; // Device shifts out here
            // Read late in the high phase, once the shifted bit has settled
            #38 rx = {rx[6:0], soData | soEnable_n};
            #2 sclkPin = 1'b0; // Device samples in here
        end
        #200 csPin_n = 1'b1;
        siPin = 1'b0; // Released data line falls to its pull-down
        #400; // Gap between two accesses
    endtask : send
endmodule : dlsc_host_model

/* File: dv/testbench.sv */
// Self-checking bench for the dual low-side switch controller
`timescale 1ns/10ps
module testbench;
    import dlsc_pkg::*;
    logic clk, rst, sclkPin, csPin_n, siPin, chipOverTemp;
    logic parallel_drive_ch1, parallel_drive_ch2;
    logic [1:0] chanOverTemp, limitActive, gateOn, slowSlew, senseSel;
    logic soData, soEnable_n, sleeping, tempWarn;
    logic channel1_status_pin, channel2_status_pin;
    logic [7:0] rx;
    logic [1:0] r, p, q;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 17208;
    int lim;

    dlsc_top uut (.clk(clk), .rst(rst), .sclkPin(sclkPin),
        .csPin_n(csPin_n), .siPin(siPin),
        .parallel_drive_ch1(parallel_drive_ch1),
        .parallel_drive_ch2(parallel_drive_ch2),
        .chanOverTemp(chanOverTemp), .limitActive(limitActive),
        .chipOverTemp(chipOverTemp), .soData(soData),
        .soEnable_n(soEnable_n), .channel1_status_pin(channel1_status_pin),
        .channel2_status_pin(channel2_status_pin), .gateOn(gateOn),
        .slowSlew(slowSlew), .senseSel(senseSel), .sleeping(sleeping),
        .tempWarn(tempWarn));

    dlsc_host_model host (.sclkPin(sclkPin), .csPin_n(csPin_n),
        .siPin(siPin), .soData(soData), .soEnable_n(soEnable_n));

    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Verdict and end of run
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task chk(input logic [7:0] got, input logic [7:0] exp, input string w);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Full frame, then back in step with the falling edge
    task frame(input logic [7:0] f);
        host.send(f, 8, rx);
        @(negedge clk);
    endtask : frame

    // Bounded wait for the gate outputs
    task wait_gate(input logic [1:0] exp, input int n);
        for (int k = 0; k < n && gateOn !== exp; k++)
            @(negedge clk);
        chk(gateOn, exp, "gate wait");
        if (gateOn !== exp)
            final_report();
    endtask : wait_gate

    // Expected drive of one channel for a source setting
    function automatic logic exp_drive(logic [1:0] s, logic a, logic b);
        case (s)
            SRC_PAR: return a;
            SRC_SER: return b;
            SRC_OR: return a | b;
            default: return a & b;
        endcase
    endfunction : exp_drive

    // Guard against a hang
    initial begin
        #760000;
        fail_count++;
        $display("[FAIL] %0t run limit reached", $time);
        final_report();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {parallel_drive_ch1, parallel_drive_ch2, chipOverTemp} = 3'h0;
        chanOverTemp = 2'h0;
        limitActive = 2'h0;
        cyc(16);
        rst = 1'b0;
        cyc(2);
        chk(gateOn, 8'h00, "gate after reset");
        chk({slowSlew, senseSel}, 8'h00, "config after reset");
        chk(soEnable_n, 8'h01, "out idle");
        // Every source mode against all request pairs, random order
        for (int s = 0; s < 4; s++) begin
            frame({CMD_IOCFG, 1'b0, 2'(s), 2'h0});
            r = 2'($random(seed));
            for (int j = 0; j < 16; j++) begin
                p = 2'(j) ^ r;
                q = 2'(j >> 2) ^ r;
                {parallel_drive_ch2, parallel_drive_ch1} = p;
                frame({CMD_ONOFF, q, 3'h0});
                cyc(8);
                chk(gateOn, {exp_drive(2'(s), p[1], q[1]),
                    exp_drive(2'(s), p[0], q[0])}, "source");
            end
        end
        // Slew per channel, no-op commands, short frame refused
        r = 2'($random(seed));
        frame({CMD_OUTCFG, 3'h0, r});
        chk(slowSlew, r, "slew");
        frame({CMD_NONE, 5'h1F});
        frame({CMD_DIAG, 5'h1F});
        host.send({CMD_OUTCFG, 5'h03 ^ 5'(r)}, 7, rx);
        cyc(8);
        chk(slowSlew, r, "no-op kept");
        frame({CMD_RESET, 5'h00});
        frame({CMD_OUTCFG, 5'h00});
        frame({CMD_IOCFG, 1'b0, SRC_PAR, 2'h0});
        // Overtemperature, autorestart
        {parallel_drive_ch2, parallel_drive_ch1} = 2'h1;
        wait_gate(2'h1, 20);
        chanOverTemp = 2'h2;
        cyc(10);
        chk(channel2_status_pin, 8'h00, "ot while off");
        chanOverTemp = 2'h3;
        wait_gate(2'h0, 10);
        cyc(2);
        chk(channel1_status_pin, 8'h00, "ot status");
        chanOverTemp = 2'h0;
        wait_gate(2'h1, 10);
        // Overtemperature, latching
        frame({CMD_OUTCFG, 5'h04});
        chanOverTemp = 2'h1;
        wait_gate(2'h0, 10);
        chanOverTemp = 2'h0;
        cyc(50);
        chk(gateOn, 8'h00, "latched off");
        parallel_drive_ch1 = 1'b0;
        cyc(10);
        parallel_drive_ch1 = 1'b1;
        wait_gate(2'h1, 20);
        // Chip warning leaves the channels alone
        chipOverTemp = 1'b1;
        cyc(6);
        chk({tempWarn, gateOn}, 8'h05, "warning");
        chipOverTemp = 1'b0;
        cyc(6);
        chk(tempWarn, 8'h00, "warning gone");
        // Switch-off overload at both slew settings
        for (int s = 0; s < 2; s++) begin
            frame({CMD_OUTCFG, 3'h0, s[0], s[0]});
            lim = s ? OFFDLY_SLOW_CYC : OFFDLY_FAST_CYC;
            limitActive = 2'h1;
            cyc(lim - 10);
            chk(gateOn, 8'h01, "before switch-off");
            wait_gate(2'h0, 40);
            limitActive = 2'h0;
            cyc(20);
            chk({channel1_status_pin, gateOn}, 8'h00, "overload latched");
            parallel_drive_ch1 = 1'b0;
            cyc(10);
            parallel_drive_ch1 = 1'b1;
            wait_gate(2'h1, 20);
        end
        // Limit mode chosen while on, fault after filter time
        frame({CMD_IOCFG, 1'b1, SRC_PAR, 2'h0});
        frame({CMD_OUTCFG, 5'h08});
        limitActive = 2'h1;
        cyc(FILTER_CYC - 20);
        chk({channel1_status_pin, gateOn}, 8'h05, "no fault yet");
        cyc(60);
        chk({channel1_status_pin, gateOn}, 8'h01, "limit fault");
        limitActive = 2'h0;
        frame({CMD_DIAG, 5'h00});
        chk(rx, 8'h02, "diag read");
        chk(channel1_status_pin, 8'h01, "diag cleared");
        // Sleep and wake
        frame({CMD_OUTCFG, 5'h03});
        frame({CMD_IOCFG, 1'b0, SRC_SER, 2'h2});
        frame({CMD_ONOFF, 2'h3, 3'h0});
        wait_gate(2'h3, 20);
        frame({CMD_SLEEP, 5'h00});
        cyc(4);
        chk({sleeping, gateOn}, 8'h04, "asleep");
        frame({CMD_ONOFF, 2'h3, 3'h0});
        chk({sleeping, gateOn}, 8'h04, "sleep refuses");
        frame({CMD_WAKE, 5'h00});
        cyc(WAKE_CYC - 80);
        chk(sleeping, 8'h01, "waking");
        cyc(100);
        chk({sleeping, slowSlew, gateOn}, 8'h0C, "awake");
        chk(senseSel, 8'h02, "sense kept");
        parallel_drive_ch2 = 1'b1;
        frame({CMD_IOCFG, 1'b0, SRC_PAR, 2'h0});
        wait_gate(2'h3, 20);
        final_report();
    end
endmodule : testbench
